// *** dv/bcx_exec_tb.sv ***
`timescale 1ns/10ps
module bcx_exec_tb;
  import bcx_pkg::*;
  typedef struct {
    logic [15:0] w1;
    logic [15:0] w2;
    logic [7:0]  wr;
    logic [9:0]  st;
    logic [3:0]  bs;
    logic        x;
    logic [11:0] ad;
    logic [7:0]  mi;
    logic [7:0]  mo;
    logic [7:0]  wo;
    logic [9:0]  so;
  } bcx_row_t;
  logic              ref_clk;
  logic              rst_b;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [PC_W-1:0]   prog_addr;
  logic [15:0]       prog_rdata;
  logic [11:0]       dmem_addr;
  logic              dmem_re;
  logic [7:0]        dmem_rdata;
  logic              dmem_we;
  logic [7:0]        dmem_wdata;
  logic [11:0]       idx_base;
  logic              wdt_clear;
  logic              stack_push;
  logic [PC_W-1:0]   return_stack_top;
  logic [31:0]       rd;
  logic              er;
  logic [31:0]       sh = 32'h0;
  logic              is_call;
  bcx_row_t          r;
  int                mismatches = 0;
  int                total_checks = 0;
  int                cyc = 0;
  int                nw = 0;
  int                np = 0;
  int                lastp = 0;
  int                per = 0;
  int                w0;
  int                p0;
  bcx_row_t rows [15] = '{
    '{16'h6A20, 16'h0000, 8'h11, 10'h300, 4'h0, 1'b0, 12'h020, 8'h5A, 8'h00, 8'h11, 10'h304},
    '{16'h6A80, 16'h0000, 8'h11, 10'h300, 4'h0, 1'b0, 12'hF80, 8'h77, 8'h00, 8'h11, 10'h304},
    '{16'h6B10, 16'h0000, 8'h11, 10'h300, 4'h3, 1'b0, 12'h310, 8'h77, 8'h00, 8'h11, 10'h304},
    '{16'h6A5F, 16'h0000, 8'h11, 10'h300, 4'h0, 1'b1, 12'h45F, 8'h77, 8'h00, 8'h11, 10'h304},
    '{16'h6A60, 16'h0000, 8'h11, 10'h300, 4'h0, 1'b1, 12'hF60, 8'h77, 8'h00, 8'h11, 10'h304},
    '{16'h1E30, 16'h0000, 8'h11, 10'h304, 4'h0, 1'b0, 12'h030, 8'h13, 8'hEC, 8'h11, 10'h310},
    '{16'h1C30, 16'h0000, 8'h11, 10'h304, 4'h0, 1'b0, 12'h030, 8'h13, 8'h13, 8'hEC, 10'h310},
    '{16'h1E30, 16'h0000, 8'h11, 10'h310, 4'h0, 1'b0, 12'h030, 8'hFF, 8'h00, 8'h11, 10'h304},
    '{16'h1F30, 16'h0000, 8'h11, 10'h315, 4'h2, 1'b0, 12'h230, 8'h80, 8'h7F, 8'h11, 10'h301},
    '{16'h0004, 16'h0000, 8'h11, 10'h000, 4'h0, 1'b0, 12'h020, 8'h12, 8'h12, 8'h11, 10'h300},
    '{16'hE002, 16'h6A41, 8'h11, 10'h304, 4'h0, 1'b0, 12'h041, 8'hAA, 8'hAA, 8'h11, 10'h304},
    '{16'hE002, 16'h6A41, 8'h11, 10'h300, 4'h0, 1'b0, 12'h041, 8'hAA, 8'h00, 8'h11, 10'h304},
    '{16'hE0FF, 16'h6A41, 8'h11, 10'h304, 4'h0, 1'b0, 12'h041, 8'hAA, 8'hAA, 8'h11, 10'h304},
    '{16'hED05, 16'hF000, 8'h3C, 10'h305, 4'hA, 1'b0, 12'h020, 8'h12, 8'h12, 8'h3C, 10'h305},
    '{16'hEC05, 16'hF000, 8'h11, 10'h300, 4'h1, 1'b0, 12'h020, 8'h12, 8'h12, 8'h11, 10'h300}
  };

  bcx_exec i_bcx_exec (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .prog_addr, .prog_rdata, .dmem_addr, .dmem_re, .dmem_rdata, .dmem_we, .dmem_wdata,
    .idx_base, .wdt_clear, .stack_push, .return_stack_top);
  bcx_mem_model i_bcx_mem_model (.ref_clk, .prog_addr, .prog_rdata, .dmem_addr, .dmem_re, .dmem_rdata,
    .dmem_we, .dmem_wdata);

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
    begin
      $display("[ PASS ]");
    end
    else
    begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Pulse counters and the hang guard live on the clock
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (wdt_clear === 1'b1)
    begin
      nw <= nw + 1;
    end
    if (stack_push === 1'b1)
    begin
      np <= np + 1;
      per <= cyc - lastp;
      lastp <= cyc;
    end
    if (cyc == 10000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Entered just after a rising edge; holds the request until pready is sampled high.
  // Only the bench's cycle ceiling ends a wait for a slave that never answers.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Halting takes effect only at a cycle start; a pending no-op resumes with the next run
  task automatic run(input logic x, input int n);
    apb(1'b1, REG_CTRL, {30'h0, x, 1'b1});
    repeat (n) @(posedge ref_clk);
    apb(1'b1, REG_CTRL, {30'h0, x, 1'b0});
    repeat (12) @(posedge ref_clk);
  endtask

  task automatic setup(input logic [15:0] a, input logic [15:0] b, input logic [9:0] st);
    for (int i = 0; i < 1024; i++)
    begin
      i_bcx_mem_model.rom[i] = 16'h0000;
    end
    i_bcx_mem_model.rom[0] = a;
    i_bcx_mem_model.rom[1] = b;
    apb(1'b1, REG_PC, 32'h0);
    apb(1'b1, REG_STATUS, {22'h0, st});
  endtask

  initial
  begin
    rst_b <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    idx_base <= 12'h400;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 7; i++)
    begin
      rdc(12'(i * 4), (i == 1) ? 32'h300 : 32'h0);
    end
    apb(1'b0, 12'h01C, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, REG_STACK, 32'h1234);
    rdc(REG_STACK, 32'h0);
    foreach (rows[i])
    begin
      r = rows[i];
      setup(r.w1, r.w2, r.st);
      apb(1'b1, REG_WREG, {24'h0, r.wr});
      apb(1'b1, REG_BANK, {28'h0, r.bs});
      i_bcx_mem_model.dmem[r.ad] = r.mi;
      w0 = nw;
      p0 = np;
      run(r.x, 60);
      chk({24'h0, i_bcx_mem_model.dmem[r.ad]}, {24'h0, r.mo});
      rdc(REG_WREG, {24'h0, r.wo});
      rdc(REG_STATUS, {22'h0, r.so});
      chk(32'(nw - w0), {31'h0, r.w1 === OPC_WDOG_RESTART});
      is_call = (r.w1[15:9] === OPC_CALL);
      chk(32'(np - p0), {31'h0, is_call});
      if (is_call)
      begin
        if (r.w1[8])
        begin
          sh = {12'h0, r.bs, r.st[7:0], r.wr};
        end
        rdc(REG_SHADOW, sh);
        rdc(REG_STACK, 32'h4);
      end
    end
    // Far call landing on a taken branch that spins on itself
    setup(16'hEC00, 16'hF001, 10'h304);
    i_bcx_mem_model.rom[256] = 16'hE0FF;
    run(1'b0, 80);
    rdc(REG_PC, 32'h200);
    chk({11'h0, return_stack_top}, 32'h4);
    // A call to itself repeats once per two instruction cycles
    setup(16'hEC00, 16'hF000, 10'h300);
    run(1'b0, 60);
    chk(32'(per), 32'h8);
    tally_and_finish();
  end
endmodule // bcx_exec_tb

// *** dv/bcx_mem_model.sv ***
`timescale 1ns/10ps
module bcx_mem_model (
  input  logic                        ref_clk,
  input  logic [bcx_pkg::PC_W-1:0]    prog_addr,
  output logic [15:0]                 prog_rdata,
  input  logic [bcx_pkg::DADDR_W-1:0] dmem_addr,
  input  logic                        dmem_re,
  output logic [7:0]                  dmem_rdata,
  input  logic                        dmem_we,
  input  logic [7:0]                  dmem_wdata
);
  import bcx_pkg::*;
  logic [15:0] rom [1024];
  logic [7:0]  dmem [4096];
  // Words past the small ROM read as zero, which the core runs as a no-op
  assign prog_rdata = (prog_addr[PC_W-1:11] == '0) ? rom[prog_addr[10:1]] : 16'h0000;
  // Outside a read strobe the bus shows the inverted byte, so a late sample cannot pass
  assign dmem_rdata = dmem_re ? dmem[dmem_addr] : ~dmem[dmem_addr];
  always @(posedge ref_clk)
  begin
    if (dmem_we === 1'b1)
    begin
      dmem[dmem_addr] <= dmem_wdata;
    end
  end
endmodule // bcx_mem_model

// *** rtl/bcx_bank_addr.sv ***
`timescale 1ns/10ps
module bcx_bank_addr #(
  parameter int DADDR_W = bcx_pkg::DADDR_W
) (
  input  logic [7:0]         f,
  input  logic               acc,
  input  logic [DADDR_W-9:0] bank,
  input  logic               xinst,
  input  logic [DADDR_W-1:0] idx_base,
  output logic [DADDR_W-1:0] addr
);
  import bcx_pkg::*;

  if (DADDR_W < 9)
  begin : g_chk
    $error("bcx_bank_addr: DADDR_W must exceed 8");
  end

  always_comb
  begin
    if (acc)
      addr = {bank, f};
    else if (xinst && (f <= IDX_MAX))
      addr = idx_base + {{(DADDR_W-8){1'b0}}, f};
    else if (f < ACC_SPLIT)
      addr = {{(DADDR_W-8){1'b0}}, f};
    else
      addr = {{(DADDR_W-8){1'b1}}, f};
  end
endmodule // bcx_bank_addr

// *** rtl/bcx_exec.sv ***
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module bcx_exec (
  input  logic                          ref_clk,
  input  logic                          rst_b,
  input  logic                          psel,
  input  logic                          penable,
  input  logic                          pwrite,
  input  logic [bcx_pkg::APB_AW-1:0]    paddr,
  input  logic [31:0]                   pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic [bcx_pkg::PC_W-1:0]      prog_addr,
  input  logic [15:0]                   prog_rdata,
  output logic [bcx_pkg::DADDR_W-1:0]   dmem_addr,
  output logic                          dmem_re,
  input  logic [7:0]                    dmem_rdata,
  output logic                          dmem_we,
  output logic [7:0]                    dmem_wdata,
  input  logic [bcx_pkg::DADDR_W-1:0]   idx_base,
  output logic                          wdt_clear,
  output logic                          stack_push,
  output logic [bcx_pkg::PC_W-1:0]      return_stack_top
);
  import bcx_pkg::*;

  localparam int BANK_W = DADDR_W - 8;

  bcx_phase_t         phase;
  bcx_exec_t          ex_r;
  logic [15:0]        ir_r;
  logic [15:0]        dec_word;
  logic [PC_W-1:0]    pc_r;
  logic [PC_W-1:0]    boff;
  logic [PC_W-1:0]    call_tgt;
  logic [7:0]         klo_r;
  logic               br_take_r;
  logic [7:0]         wreg_r;
  logic [7:0]         status_r;
  logic [BANK_W-1:0]  bank_select_reg_r;
  logic [7:0]         working_shadow_r;
  logic [7:0]         flags_shadow_r;
  logic [BANK_W-1:0]  bank_select_shadow_r;
  logic               timeout_flag_n_r;
  logic               powerdown_flag_n_r;
  logic               run_r;
  logic               xinst_r;
  logic [7:0]         rd_r;
  logic [7:0]         res_c;
  logic [DADDR_W-1:0] fa;
  logic               ex_run;
  logic               q1_go;
  logic               halted;
  logic               is_branch;
  logic               is_call;
  logic               is_clear;
  logic               is_restart;
  logic               is_invert;
  logic               apb_hit;
  logic               apb_wr;
  logic [31:0]        rd_mux;

  bcx_phase_seq u_phase (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .run     (run_r),
    .phase   (phase)
  );

  // In Q1 the word is still on the fetch bus; later phases use the latched copy
  assign dec_word = (phase == PH_Q1) ? prog_rdata : ir_r;
  assign is_branch  = (dec_word[15:8] == OPC_BRANCH_ZERO);
  assign is_call    = (dec_word[15:9] == OPC_CALL);
  assign is_clear   = (dec_word[15:9] == OPC_CLEAR_FILE);
  assign is_restart = (dec_word == OPC_WDOG_RESTART);
  assign is_invert  = (dec_word[15:10] == OPC_INVERT_FILE);
  assign ex_run   = (ex_r == EX_RUN);
  assign q1_go    = (phase == PH_Q1) && run_r;
  assign halted   = (phase == PH_Q1) && !run_r;
  assign boff     = {{(PC_W-9){dec_word[7]}}, dec_word[7:0], 1'b0};
  // Second call word is not checked for its 1111 prefix; it is trusted as fetched
  assign call_tgt = {prog_rdata[11:0], klo_r, 1'b0};
  assign res_c    = is_invert ? ~rd_r : BYTE_ZERO;
  assign prog_addr = pc_r;

  bcx_bank_addr #(.DADDR_W(DADDR_W)) u_bank (
    .f        (dec_word[7:0]),
    .acc      (dec_word[BIT_ACC]),
    .bank     (bank_select_reg_r),
    .xinst    (xinst_r),
    .idx_base (idx_base),
    .addr     (fa)
  );

  // Program flow: PC, branch, call and stack
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      pc_r             <= PC_RST;
      ir_r             <= 16'h0000;
      ex_r             <= EX_RUN;
      klo_r            <= BYTE_ZERO;
      br_take_r        <= 1'b0;
      stack_push       <= 1'b0;
      return_stack_top <= PC_RST;
    end
    else
    begin
      stack_push <= 1'b0;
      if (apb_wr && (paddr == REG_PC) && halted)
        pc_r <= pwdata[PC_W-1:0];
      else
      begin
        case (phase)
          PH_Q1:
          begin
            if (run_r && ex_run)
            begin
              ir_r <= prog_rdata;
              pc_r <= pc_r + PC_STEP;
            end
          end
          PH_Q2:
          begin
            if (ex_run && is_call)
              klo_r <= ir_r[7:0];
          end
          PH_Q3:
          begin
            br_take_r <= ex_run && is_branch && status_r[STAT_Z];
            if (ex_run && is_call)
            begin
              return_stack_top <= pc_r + RET_STEP;
              stack_push       <= 1'b1;
            end
          end
          PH_Q4:
          begin
            if (ex_run && is_branch && br_take_r)
              pc_r <= pc_r + boff;
            else if (ex_run && is_call)
              pc_r <= call_tgt;
            if (ex_run && ((is_branch && br_take_r) || is_call))
              ex_r <= EX_NOP;
            else
              ex_r <= EX_RUN;
          end
          default: ex_r <= EX_RUN;
        endcase
      end
    end
  end

  // Data path: file access, working register, flags, shadows, watchdog
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      dmem_addr            <= '0;
      dmem_re              <= 1'b0;
      dmem_we              <= 1'b0;
      dmem_wdata           <= BYTE_ZERO;
      rd_r                 <= BYTE_ZERO;
      wreg_r               <= BYTE_ZERO;
      status_r             <= BYTE_ZERO;
      bank_select_reg_r    <= '0;
      working_shadow_r     <= BYTE_ZERO;
      flags_shadow_r       <= BYTE_ZERO;
      bank_select_shadow_r <= '0;
      timeout_flag_n_r     <= 1'b1;
      powerdown_flag_n_r   <= 1'b1;
      wdt_clear            <= 1'b0;
    end
    else
    begin
      wdt_clear <= 1'b0;
      // Software may only load core state while halted, so it never races the core
      if (apb_wr && halted)
      begin
        case (paddr)
          REG_STATUS:
          begin
            status_r           <= pwdata[7:0];
            timeout_flag_n_r   <= pwdata[STAT_TO_BIT];
            powerdown_flag_n_r <= pwdata[STAT_PWRDN_BIT];
          end
          REG_WREG: wreg_r            <= pwdata[7:0];
          REG_BANK: bank_select_reg_r <= pwdata[BANK_W-1:0];
          default:  ;
        endcase
      end
      case (phase)
        PH_Q1:
        begin
          if (q1_go && ex_run && (is_clear || is_invert))
          begin
            dmem_addr <= fa;
            dmem_re   <= 1'b1;
          end
        end
        PH_Q2:
        begin
          dmem_re <= 1'b0;
          rd_r    <= dmem_rdata;
        end
        PH_Q3:
        begin
          if (ex_run && (is_clear || (is_invert && ir_r[BIT_DEST])))
          begin
            dmem_we    <= 1'b1;
            dmem_wdata <= res_c;
          end
          if (ex_run && is_call && ir_r[BIT_CALL_S])
          begin
            working_shadow_r     <= wreg_r;
            flags_shadow_r       <= status_r;
            bank_select_shadow_r <= bank_select_reg_r;
          end
          if (ex_run && is_restart)
          begin
            wdt_clear          <= 1'b1;
            timeout_flag_n_r   <= 1'b1;
            powerdown_flag_n_r <= 1'b1;
          end
        end
        PH_Q4:
        begin
          dmem_we <= 1'b0;
          if (ex_run && is_clear)
            status_r[STAT_Z] <= 1'b1;
          if (ex_run && is_invert)
          begin
            status_r[STAT_N] <= res_c[7];
            status_r[STAT_Z] <= (res_c == BYTE_ZERO);
            if (!ir_r[BIT_DEST])
              wreg_r <= res_c;
          end
        end
        default: dmem_re <= 1'b0;
      endcase
    end
  end

  // APB slave: one wait state, read data and ready come from flops
  always_comb
  begin
    apb_hit = 1'b1;
    rd_mux  = 32'h00000000;
    case (paddr)
      REG_CTRL:   rd_mux = {30'h00000000, xinst_r, run_r};
      REG_STATUS: rd_mux = {22'h000000, powerdown_flag_n_r, timeout_flag_n_r, status_r};
      REG_WREG:   rd_mux = {24'h000000, wreg_r};
      REG_BANK:   rd_mux = {{(32-BANK_W){1'b0}}, bank_select_reg_r};
      REG_PC:     rd_mux = {{(32-PC_W){1'b0}}, pc_r};
      REG_STACK:  rd_mux = {{(32-PC_W){1'b0}}, return_stack_top};
      REG_SHADOW: rd_mux = {{(16-BANK_W){1'b0}}, bank_select_shadow_r, flags_shadow_r, working_shadow_r};
      default:    apb_hit = 1'b0;
    endcase
  end

  assign apb_wr = psel && penable && pready && pwrite && apb_hit;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      run_r   <= 1'b0;
      xinst_r <= 1'b0;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready)
      begin
        pready  <= 1'b1;
        pslverr <= !apb_hit;
        prdata  <= pwrite ? 32'h00000000 : rd_mux;
      end
      if (apb_wr && (paddr == REG_CTRL))
      begin
        run_r   <= pwdata[CTRL_RUN];
        xinst_r <= pwdata[CTRL_XINST];
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  property p_branch_taken;
    (phase == PH_Q4 && ex_run && is_branch && br_take_r) |=> (pc_r == $past(pc_r) + $past(boff)) && (ex_r == EX_NOP);
  endproperty
  a_branch_taken: assert property (p_branch_taken) else $error("taken branch target or no-op wrong");
  // The write strobe is looked at in Q4 itself, where a stray branch write would show
  property p_branch_quiet;
    (phase == PH_Q4 && ex_run && is_branch) |-> !dmem_we ##1 $stable(status_r);
  endproperty
  a_branch_quiet: assert property (p_branch_quiet) else $error("branch touched flags or wrote");
  property p_branch_seq;
    (phase == PH_Q4 && ex_run && is_branch && !br_take_r) |=> (pc_r == $past(pc_r)) && (ex_r == EX_RUN);
  endproperty
  a_branch_seq: assert property (p_branch_seq) else $error("untaken branch altered flow");
  property p_call_push;
    (phase == PH_Q3 && ex_run && is_call) |=> stack_push && (return_stack_top == $past(pc_r) + RET_STEP);
  endproperty
  a_call_push: assert property (p_call_push) else $error("call pushed wrong return address");
  property p_call_pc;
    (phase == PH_Q4 && ex_run && is_call) |=> (pc_r == $past(call_tgt)) ##1 (ex_r == EX_NOP) [*3];
  endproperty
  a_call_pc: assert property (p_call_pc) else $error("call target or no-op cycle wrong");
  property p_shadow;
    (phase == PH_Q3 && ex_run && is_call) |=> ir_r[BIT_CALL_S] ? (working_shadow_r == $past(wreg_r) &&
      flags_shadow_r == $past(status_r) && bank_select_shadow_r == $past(bank_select_reg_r)) :
      ($stable(working_shadow_r) && $stable(flags_shadow_r) && $stable(bank_select_shadow_r));
  endproperty
  a_shadow: assert property (p_shadow) else $error("shadow copy wrong");
  property p_clear;
    (phase == PH_Q3 && ex_run && is_clear) |=> (dmem_we && dmem_wdata == BYTE_ZERO) ##1 (!dmem_we && status_r[STAT_Z]);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not write zero");
  property p_restart;
    (phase == PH_Q3 && ex_run && is_restart) |=> (wdt_clear && timeout_flag_n_r && powerdown_flag_n_r) ##1 !wdt_clear;
  endproperty
  a_restart: assert property (p_restart) else $error("watchdog restart wrong");
  property p_invert_w;
    (phase == PH_Q4 && ex_run && is_invert && !ir_r[BIT_DEST]) |=> (wreg_r == ~$past(rd_r)) &&
      (status_r[STAT_N] == wreg_r[7]) && (status_r[STAT_Z] == (wreg_r == BYTE_ZERO));
  endproperty
  a_invert_w: assert property (p_invert_w) else $error("invert to working register wrong");
  property p_invert_f;
    (phase == PH_Q3 && ex_run && is_invert && ir_r[BIT_DEST]) |=> dmem_we && (dmem_wdata == ~$past(rd_r));
  endproperty
  a_invert_f: assert property (p_invert_f) else $error("invert write-back wrong");
  property p_addr;
    (q1_go && ex_run && (is_clear || is_invert)) |=> dmem_re && (dmem_addr == $past(fa)) ##1 !dmem_re;
  endproperty
  a_addr: assert property (p_addr) else $error("file address or read strobe wrong");
  property p_phase_io;
    (dmem_we |-> phase == PH_Q4) and (dmem_re |-> phase == PH_Q2);
  endproperty
  a_phase_io: assert property (p_phase_io) else $error("file access outside its phase");

  c_branch_taken: cover property (phase == PH_Q4 && ex_run && is_branch && br_take_r);
  c_call_s:       cover property (phase == PH_Q3 && ex_run && is_call && ir_r[BIT_CALL_S]);
  c_invert_w:     cover property (phase == PH_Q4 && ex_run && is_invert && !ir_r[BIT_DEST]);
  c_restart:      cover property (wdt_clear);
endmodule // bcx_exec

// *** rtl/bcx_phase_seq.sv ***
`timescale 1ns/10ps
module bcx_phase_seq (
  input  logic                ref_clk,
  input  logic                rst_b,
  input  logic                run,
  output bcx_pkg::bcx_phase_t phase
);
  import bcx_pkg::*;

  // A halt only takes hold at Q1, so a started cycle always completes
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      phase <= PH_Q1;
    else
    begin
      case (phase)
        PH_Q1:   phase <= run ? PH_Q2 : PH_Q1;
        PH_Q2:   phase <= PH_Q3;
        PH_Q3:   phase <= PH_Q4;
        PH_Q4:   phase <= PH_Q1;
        default: phase <= PH_Q1;
      endcase
    end
  end
endmodule // bcx_phase_seq

// *** rtl/bcx_pkg.sv ***
package bcx_pkg;
  localparam int PC_W    = 21;
  localparam int DADDR_W = 12;
  localparam int APB_AW  = 12;

  // Opcode patterns, compared against the top bits of the instruction word; OPC_CALL2 is never compared
  localparam logic [7:0]  OPC_BRANCH_ZERO  = 8'hE0;
  localparam logic [6:0]  OPC_CALL         = 7'h76;
  localparam logic [3:0]  OPC_CALL2        = 4'hF;
  localparam logic [6:0]  OPC_CLEAR_FILE   = 7'h35;
  localparam logic [15:0] OPC_WDOG_RESTART = 16'h0004;
  localparam logic [5:0]  OPC_INVERT_FILE  = 6'h07;

  // Instruction field positions
  localparam int BIT_CALL_S = 8;
  localparam int BIT_ACC    = 8;
  localparam int BIT_DEST   = 9;

  // Status byte layout
  localparam int STAT_C  = 0;
  localparam int STAT_DC = 1;
  localparam int STAT_Z  = 2;
  localparam int STAT_OV = 3;
  localparam int STAT_N  = 4;

  // Access bank split and indexed window limit
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [7:0] IDX_MAX   = 8'h5F;

  localparam logic [PC_W-1:0] PC_STEP  = 21'h000002;
  localparam logic [PC_W-1:0] RET_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RST   = 21'h000000;
  localparam logic [7:0]      BYTE_ZERO = 8'h00;

  // Register map, byte addresses
  localparam logic [APB_AW-1:0] REG_CTRL   = 12'h000;
  localparam logic [APB_AW-1:0] REG_STATUS = 12'h004;
  localparam logic [APB_AW-1:0] REG_WREG   = 12'h008;
  localparam logic [APB_AW-1:0] REG_BANK   = 12'h00C;
  localparam logic [APB_AW-1:0] REG_PC     = 12'h010;
  localparam logic [APB_AW-1:0] REG_STACK  = 12'h014;
  localparam logic [APB_AW-1:0] REG_SHADOW = 12'h018;

  localparam int CTRL_RUN     = 0;
  localparam int CTRL_XINST   = 1;
  localparam int STAT_TO_BIT  = 8;
  localparam int STAT_PWRDN_BIT = 9;

  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } bcx_phase_t;

  typedef enum logic [1:0] {
    EX_RUN = 2'b01,
    EX_NOP = 2'b10
  } bcx_exec_t;
endpackage
